// ### mht_timing_regs.sv
// handshake timing register bank with the timers that consume it
`timescale 1ns/10ps
module mht_timing_regs
  import mht_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
)
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // register port
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  // mode inputs
  input wire logic [1:0] i_intrusion_block_mode,
  input wire logic i_alarm_mode,
  // cadence detectors
  input wire logic i_busy_tone,
  input wire logic i_ringback_tone,
  output logic o_busy_det,
  output logic o_ringback_det,
  // persistence qualifiers
  input wire logic [NQ-1:0] i_qual_level,
  output logic [NQ-1:0] o_qual_det,
  output logic o_kissoff_echo,
  // interval timers
  input wire logic [NR-1:0] i_run_start,
  output logic [NR-1:0] o_run_active,
  output logic [NR-1:0] o_run_done
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

  mht_state_t s_q;
  mht_state_t s_d;
  logic [7:0] bus_off;
  logic bus_hit;
  logic [NQ-1:0][CNT_W-1:0] qlim;
  logic [NR-1:0][CNT_W-1:0] rdur;
  logic [NR-1:0] rstart;

  // register value by address
  function automatic logic [7:0] rv(input mht_state_t s, input logic [7:0] a);
    logic [7:0] off;
    off = a - REG_BASE;
    return s.regs[off[5:0]];
  endfunction : rv

  // count scaled to ticks
  function automatic logic [CNT_W-1:0] scl(input logic [7:0] v, input int unsigned u);
    return CNT_W'(v) * CNT_W'(u);
  endfunction : scl

  // address decode, holes and out-of-range addresses are unmapped
  assign bus_off = i_reg_addr - REG_BASE;
  assign bus_hit = (i_reg_addr >= REG_BASE) && (i_reg_addr <= REG_LAST)
                   && REG_VALID[bus_off[5:0]];

  // ----------------------------------------------------------------------
  // limits and durations in ticks
  // ----------------------------------------------------------------------
  always_comb
  begin
    qlim[Q_DIAL] = scl(rv(s_q, A_DIAL_TIME), U_10MS);          // [R3]
    qlim[Q_UNSCR] = scl(rv(s_q, A_UNSCR_LEN), 1);              // [R6]
    qlim[Q_SCR2400] = scl(rv(s_q, A_RX_SCR2400), 1);           // [R14]
    qlim[Q_TURN] = scl(rv(s_q, A_TURN_CAR), 1);                // [R15]
    qlim[Q_LOSS] = scl(rv(s_q, A_SLAVE_LOSS), 1);              // [R17]
    qlim[Q_ANS] = scl(rv(s_q, A_RX_ANS), 1);                   // [R20]
    qlim[Q_KISS] = scl(rv(s_q, A_KISS_LEN), U_10MS);           // [R22]
    qlim[Q_SCR1200] = scl(rv(s_q, A_RX_SCR1200), 1);
    // zero seconds falls back to the short length
    if (rv(s_q, A_ANS_SECS) != 8'h00)
      rdur[R_ANS_TONE] = scl(rv(s_q, A_ANS_SECS), U_1S);       // [R4]
    else
      rdur[R_ANS_TONE] = scl(rv(s_q, A_ANS_SHORT), 1);         // [R4]
    rdur[R_ANS_TX] = scl(rv(s_q, A_ANS_TX_DLY), 1);            // [R5]
    rdur[R_SCR_DLY] = scl(rv(s_q, A_SCR_DLY), U_53MS);         // [R7]
    rdur[R_SCR_TX] = scl(rv(s_q, A_SCR_LEN), 1);               // [R8]
    rdur[R_DATA_DLY] = scl(rv(s_q, A_DATA_LO), 1)
                       + scl(rv(s_q, A_DATA_HI), U_HIGH);      // [R9]
    rdur[R_S1] = scl(rv(s_q, A_S1_LEN), 1);                    // [R10]
    rdur[R_ONES1200] = scl(rv(s_q, A_ONES1200), U_53MS);       // [R11]
    rdur[R_ONES2400] = scl(rv(s_q, A_ONES2400_LO), 1)
                       + scl(rv(s_q, A_ONES2400_HI), U_HIGH);  // [R12]
    rdur[R_INTR] = scl(rv(s_q, A_INTR_SUSP), U_500MS);         // [R13]
    rdur[R_TURN] = CNT_W'(U_TURN_MIN) + scl(rv(s_q, A_TURN_TO), 1); // [R16]
    rdur[R_REV] = scl(rv(s_q, A_REV_TO), 1);                   // [R18]
    rdur[R_FSK] = scl(rv(s_q, A_FSK_LO), 1)
                  + scl(rv(s_q, A_FSK_HI), U_HIGH);            // [R19]
    rdur[R_OVC] = scl(rv(s_q, A_OVC_DLY), 1);                  // [R21]
  end

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    logic [7:0] on_t;
    logic [7:0] off_t;
    logic [7:0] dl_t;
    logic [PER_W-1:0] unit;
    logic [PER_W-1:0] per;
    logic lvl;
    logic ok;
    on_t = 8'h00;
    off_t = 8'h00;
    dl_t = 8'h00;
    unit = '0;
    per = '0;
    lvl = 1'b0;
    ok = 1'b0;
    s_d = s_q;
    rstart = i_run_start;

    // register port: read data stand for one cycle only
    s_d.rdata = 8'h00;
    if (i_reg_rd && bus_hit)
      s_d.rdata = s_q.regs[bus_off[5:0]];                      // [R23]
    if (i_reg_wr && bus_hit)
      s_d.regs[bus_off[5:0]] = i_reg_wdata;                    // [R23]

    // prescaler, one tick every 5/3 ms; all times share it
    s_d.tick = 1'b0;
    if (s_q.pre == TICK_LAST)
    begin
      s_d.pre = '0;
      s_d.tick = 1'b1;
    end
    else
      s_d.pre = TICK_W'(s_q.pre + 1'b1);

    // persistence: the level must hold without a gap, any drop restarts
    for (int q = 0; q < NQ; q++)
    begin
      if (!i_qual_level[q])
      begin
        s_d.qcnt[q] = '0;
        s_d.qdet[q] = 1'b0;
      end
      else
      begin
        if (s_q.tick && (s_q.qcnt[q] != '1))
          s_d.qcnt[q] = CNT_W'(s_q.qcnt[q] + 1'b1);
        // kissoff must last strictly longer than its limit
        if (q == Q_KISS)
          s_d.qdet[q] = s_d.qcnt[q] > qlim[q];                 // [R22]
        else
          s_d.qdet[q] = s_d.qcnt[q] >= qlim[q];                // [R3] [R6] [R14] [R15] [R17] [R20]
      end
    end
    s_d.kiss_echo = i_alarm_mode && s_d.qdet[Q_KISS] && !s_q.qdet[Q_KISS]; // [R22]

    // handshake chaining: answer tone end starts tx delay, unscrambled ones detect starts scr delay, whose end starts scr tx
    rstart[R_ANS_TX] = i_run_start[R_ANS_TX] | s_q.rdone[R_ANS_TONE]; // [R5]
    rstart[R_SCR_DLY] = i_run_start[R_SCR_DLY]
                        | (s_d.qdet[Q_UNSCR] & ~s_q.qdet[Q_UNSCR]);   // [R7]
    rstart[R_SCR_TX] = i_run_start[R_SCR_TX] | s_q.rdone[R_SCR_DLY];  // [R8]
    // suspension only in the mode that asks for it
    rstart[R_INTR] = i_run_start[R_INTR]
                     && (i_intrusion_block_mode == IB_SUSPEND);       // [R13]

    // interval timers: load on start, count down on ticks; restart reloads
    for (int r = 0; r < NR; r++)
    begin
      s_d.rdone[r] = 1'b0;
      if (rstart[r])
      begin
        s_d.rcnt[r] = rdur[r];                                 // [R4] [R9] [R10] [R11] [R12]
        s_d.rdone[r] = (rdur[r] == '0);
      end
      else if (s_q.tick && (s_q.rcnt[r] != '0))
      begin
        s_d.rcnt[r] = CNT_W'(s_q.rcnt[r] - 1'b1);              // [R16] [R18] [R19] [R21]
        s_d.rdone[r] = (s_q.rcnt[r] == CNT_W'(1));
      end
      s_d.ract[r] = (s_d.rcnt[r] != '0);
    end

    // cadence: each edge closes a period and judges it against its window
    for (int c = 0; c < 2; c++)
    begin
      if (c == 0)
      begin
        lvl = i_busy_tone;
        on_t = rv(s_q, A_BUSY_ON);
        off_t = rv(s_q, A_BUSY_OFF);
        dl_t = rv(s_q, A_BUSY_DELTA);
        unit = PER_W'(U_10MS);
      end
      else
      begin
        lvl = i_ringback_tone;
        on_t = rv(s_q, A_RB_ON);
        off_t = rv(s_q, A_RB_OFF);
        dl_t = rv(s_q, A_RB_DELTA);
        unit = PER_W'(U_53MS);
      end
      per = s_q.cad_cnt[c];
      s_d.cad_lvl[c] = lvl;
      if (lvl != s_q.cad_lvl[c])
      begin
        s_d.cad_cnt[c] = '0;
        if (!lvl)
        begin
          // on period ended, both bounds strict
          ok = ((on_t <= dl_t) || (per > PER_W'(on_t - dl_t) * unit))
               && (per < (PER_W'(on_t) + PER_W'(dl_t)) * unit);  // [R1] [R2]
          s_d.cad_onok[c] = ok;
          if (!ok)
            s_d.cad_det[c] = 1'b0;
        end
        else
        begin
          // off period ended, a full good cycle confirms the tone
          ok = ((off_t <= dl_t) || (per > PER_W'(off_t - dl_t) * unit))
               && (per < (PER_W'(off_t) + PER_W'(dl_t)) * unit); // [R1] [R2]
          s_d.cad_det[c] = s_q.cad_onok[c] && ok;
          s_d.cad_onok[c] = 1'b0;
        end
      end
      else if (s_q.tick && (s_q.cad_cnt[c] != '1))
        s_d.cad_cnt[c] = PER_W'(s_q.cad_cnt[c] + 1'b1);
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      s_q <= '0;
      s_q.regs <= REG_RST;                                     // [R23]
    end
    else
      s_q <= s_d;
  end

  // outputs straight from the state flops
  assign o_reg_rdata = s_q.rdata;
  assign o_busy_det = s_q.cad_det[0];
  assign o_ringback_det = s_q.cad_det[1];
  assign o_qual_det = s_q.qdet;
  assign o_kissoff_echo = s_q.kiss_echo;
  assign o_run_active = s_q.ract;
  assign o_run_done = s_q.rdone;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_sys_rst);

  // a written value reads back in the cycle after the read strobe
  reg_readback_a: assert property ( // [R23]
    (i_reg_wr && bus_hit) ##1 (i_reg_rd && (i_reg_addr == $past(i_reg_addr)))
    |=> (o_reg_rdata == $past(i_reg_wdata, 2)))
    else $error("register read back differs from written value");

  // dial tone reported only with its level held long enough
  dial_tone_det_a: assert property ( // [R3]
    $rose(o_qual_det[Q_DIAL]) |-> $past(i_qual_level[Q_DIAL])
    && (s_q.qcnt[Q_DIAL] >= qlim[Q_DIAL]))
    else $error("dial tone reported before its time");

  // kissoff must be strictly longer than its limit
  kiss_strict_a: assert property ( // [R22]
    o_qual_det[Q_KISS] |-> (s_q.qcnt[Q_KISS] > qlim[Q_KISS]))
    else $error("kissoff accepted at or below its limit");

  // echo only in alarm mode and only on a fresh kissoff
  kiss_echo_a: assert property ( // [R22]
    o_kissoff_echo |-> $past(i_alarm_mode) && $rose(o_qual_det[Q_KISS]))
    else $error("kissoff echo without cause");

  // answer tone length follows the seconds register or its fallback
  ans_tone_len_a: assert property ( // [R4]
    $rose(o_run_active[R_ANS_TONE]) |-> (s_q.rcnt[R_ANS_TONE] ==
    ((rv(s_q, A_ANS_SECS) != 8'h00) ? scl(rv(s_q, A_ANS_SECS), U_1S)
    : scl(rv(s_q, A_ANS_SHORT), 1))) || $past(i_reg_wr))
    else $error("answer tone length wrongly loaded");

  // transmit delay follows the end of the answer tone at once
  ans_tx_chain_a: assert property ( // [R5]
    (o_run_done[R_ANS_TONE] && (rv(s_q, A_ANS_TX_DLY) != 8'h00) && !i_reg_wr)
    |=> o_run_active[R_ANS_TX])
    else $error("transmit delay did not follow answer tone");

  // scrambled ones delay starts with unscrambled ones detection
  scr_delay_chain_a: assert property ( // [R7]
    ($rose(o_qual_det[Q_UNSCR]) && (rdur[R_SCR_DLY] != '0)) |-> o_run_active[R_SCR_DLY])
    else $error("scrambled ones delay not started");

  // intrusion suspension only in its mode
  intr_mode_a: assert property ( // [R13]
    $rose(o_run_active[R_INTR]) |-> ($past(i_intrusion_block_mode) == IB_SUSPEND))
    else $error("intrusion suspended in wrong mode");

  // turnaround search carries its fixed minimum plus the timeout count
  turn_window_a: assert property ( // [R16]
    $rose(o_run_active[R_TURN]) |-> (s_q.rcnt[R_TURN] ==
    CNT_W'(U_TURN_MIN) + CNT_W'(rv(s_q, A_TURN_TO))))
    else $error("turnaround search length wrongly loaded");

  // a cadence is confirmed only after a good on period
  busy_cadence_a: assert property ( // [R1]
    $rose(o_busy_det) |-> $past(s_q.cad_onok[0]) && $past(i_busy_tone)
    && !$past(i_busy_tone, 2))
    else $error("busy tone confirmed without a valid on period");

  // main scenarios
  busy_seen_c: cover property ($rose(o_busy_det));
  ringback_seen_c: cover property ($rose(o_ringback_det));
  ans_chain_c: cover property (o_run_done[R_ANS_TONE] ##[1:8] o_run_active[R_ANS_TX]);
  kiss_echo_c: cover property (o_kissoff_echo);

endmodule : mht_timing_regs

// ### mht_pkg.sv
// constants, register map and state layout for the modem handshake timing bank
//
// Function
// R1: Busy tone valid only when on and off periods lie strictly within target plus/minus delta.
// R2: Ringback valid only when on and off periods lie strictly within window, 53.333 ms units.
// R3: Dial tone reported only after staying valid for dial_tone_time times 10 ms.
// R4: Answer tone lasts answer_tone_secs seconds, or answer_tone_short units when seconds are zero.
// R5: Data transmit starts answer_to_tx_delay units after the answer tone ends.
// R6: Unscrambled ones count as detected after persisting unscr_ones_len units.
// R7: Scrambled ones transmit starts scr_ones_delay times 53.3 ms after unscrambled ones detected.
// R8: Scrambled ones are transmitted for scr_ones_len units.
// R9: Data connection delayed by low count units plus high count times 256 units.
// R10: Unscrambled S1 pattern is sent for s1_pattern_len units.
// R11: 1200 bps scrambled ones sent at least v22bis_1200_ones_len times 53.3 ms.
// R12: 2400 bps scrambled ones sent at least low plus high times 256 units.
// R13: Intrusion algorithm suspended from dialing start for intrusion_suspend times 500 ms, mode 10.
// R14: 2400 bps scrambled ones detected after persisting rx_scr_ones_2400 units.
// R15: Direct turnaround needs carrier for at least turnaround_carrier_len units.
// R16: Direct turnaround search lasts 426.66 ms plus turnaround_timeout units.
// R17: Reverse turnaround search begins after carrier lost for slave_loss_len units.
// R18: Each reverse turnaround carrier search limited to reverse_carrier_timeout units.
// R19: FSK connection delayed by low count units plus high count times 256 units.
// R20: Answer tone recognised after persisting rx_answer_tone_len units.
// R21: Overcurrent sampled overcurrent_check_delay units after going off-hook.
// R22: In alarm modes, echo k when kissoff tone lasts longer than kissoff_len times 10 ms.
// R23: Each timing register is an 8-bit host read/write count with a reset value.
package mht_pkg;

  // ----------------------------------------------------------------------
  // time base: one tick is 5/3 ms
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ = 40;
  localparam int BASE_NUM_US = 5000;
  localparam int BASE_DEN = 3;
  // least tick length, rounded up to whole cycles
  localparam int TICK_CYCLES_DEF = (BASE_NUM_US * CLK_MHZ + BASE_DEN - 1) / BASE_DEN;
  localparam int TICK_W = 17;
  localparam int CNT_W = 18;
  localparam int PER_W = 16;
  localparam int TIME_10MS_US = 10000;
  localparam int TIME_500MS_US = 500000;
  localparam int TIME_1S_US = 1000000;
  localparam int U_10MS = TIME_10MS_US * BASE_DEN / BASE_NUM_US;
  localparam int U_500MS = TIME_500MS_US * BASE_DEN / BASE_NUM_US;
  localparam int U_1S = TIME_1S_US * BASE_DEN / BASE_NUM_US;
  localparam int U_53MS = 32;      // 53.333 ms in ticks
  localparam int U_HIGH = 256;     // weight of a high count byte
  localparam int U_TURN_MIN = 256; // 426.66 ms in ticks

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] REG_BASE = 8'h16;
  localparam logic [7:0] REG_LAST = 8'h36;
  localparam int NREG = 33;
  localparam logic [7:0] A_BUSY_ON = 8'h16;
  localparam logic [7:0] A_BUSY_OFF = 8'h17;
  localparam logic [7:0] A_BUSY_DELTA = 8'h18;
  localparam logic [7:0] A_RB_ON = 8'h19;
  localparam logic [7:0] A_RB_OFF = 8'h1A;
  localparam logic [7:0] A_RB_DELTA = 8'h1B;
  localparam logic [7:0] A_DIAL_TIME = 8'h1C;
  localparam logic [7:0] A_ANS_SECS = 8'h1E;
  localparam logic [7:0] A_ANS_TX_DLY = 8'h1F;
  localparam logic [7:0] A_UNSCR_LEN = 8'h20;
  localparam logic [7:0] A_SCR_DLY = 8'h21;
  localparam logic [7:0] A_SCR_LEN = 8'h22;
  localparam logic [7:0] A_DATA_LO = 8'h23;
  localparam logic [7:0] A_DATA_HI = 8'h24;
  localparam logic [7:0] A_S1_LEN = 8'h25;
  localparam logic [7:0] A_ONES1200 = 8'h26;
  localparam logic [7:0] A_ONES2400_LO = 8'h27;
  localparam logic [7:0] A_ONES2400_HI = 8'h28;
  localparam logic [7:0] A_INTR_SUSP = 8'h29;
  localparam logic [7:0] A_RX_SCR2400 = 8'h2A;
  localparam logic [7:0] A_TURN_CAR = 8'h2B;
  localparam logic [7:0] A_TURN_TO = 8'h2C;
  localparam logic [7:0] A_SLAVE_LOSS = 8'h2D;
  localparam logic [7:0] A_REV_TO = 8'h2E;
  localparam logic [7:0] A_FSK_LO = 8'h2F;
  localparam logic [7:0] A_FSK_HI = 8'h30;
  localparam logic [7:0] A_RX_ANS = 8'h31;
  localparam logic [7:0] A_OVC_DLY = 8'h32;
  localparam logic [7:0] A_ANS_SHORT = 8'h34;
  localparam logic [7:0] A_RX_SCR1200 = 8'h35;
  localparam logic [7:0] A_KISS_LEN = 8'h36;
  // holes at 0x1D and 0x33 are unmapped
  localparam logic [NREG-1:0] REG_VALID = 33'h1_DFFF_FF7F;
  // reset values, entry 0 is address 0x16
  localparam logic [NREG-1:0][7:0] REG_RST = {
    8'h30, 8'hA2, 8'h5A, 8'h00, 8'h0C, 8'h3C, 8'h00, 8'h3C, 8'hF0, 8'h0C, 8'h08,
    8'h18, 8'hD2, 8'h00, 8'h08, 8'h78, {9{8'h0A}}, 8'h00, {5{8'h0A}}, 8'h32, 8'h32};
  localparam logic [1:0] IB_SUSPEND = 2'b10;

  // ----------------------------------------------------------------------
  // channels: persistence qualifiers and one-shot intervals
  // ----------------------------------------------------------------------
  localparam int NQ = 8;
  localparam int Q_DIAL = 0;
  localparam int Q_UNSCR = 1;
  localparam int Q_SCR2400 = 2;
  localparam int Q_TURN = 3;
  localparam int Q_LOSS = 4;
  localparam int Q_ANS = 5;
  localparam int Q_KISS = 6;
  localparam int Q_SCR1200 = 7;
  localparam int NR = 13;
  localparam int R_ANS_TONE = 0;
  localparam int R_ANS_TX = 1;
  localparam int R_SCR_DLY = 2;
  localparam int R_SCR_TX = 3;
  localparam int R_DATA_DLY = 4;
  localparam int R_S1 = 5;
  localparam int R_ONES1200 = 6;
  localparam int R_ONES2400 = 7;
  localparam int R_INTR = 8;
  localparam int R_TURN = 9;
  localparam int R_REV = 10;
  localparam int R_FSK = 11;
  localparam int R_OVC = 12;

  // whole state of the bank
  typedef struct packed {
    logic [NREG-1:0][7:0] regs;
    logic [7:0] rdata;
    logic [TICK_W-1:0] pre;
    logic tick;
    logic [NQ-1:0][CNT_W-1:0] qcnt;
    logic [NQ-1:0] qdet;
    logic [NR-1:0][CNT_W-1:0] rcnt;
    logic [NR-1:0] ract;
    logic [NR-1:0] rdone;
    logic [1:0] cad_lvl;
    logic [1:0][PER_W-1:0] cad_cnt;
    logic [1:0] cad_onok;
    logic [1:0] cad_det;
    logic kiss_echo;
  } mht_state_t;

endpackage : mht_pkg

// ### mht_far_end.sv
// far-end tone source that plays an on/off cadence toward the bank
`timescale 1ns/10ps
module mht_far_end
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // cadence control
  input wire logic i_en,
  input wire logic [15:0] i_on_cyc,
  input wire logic [15:0] i_off_cyc,
  // line tone
  output logic o_tone
);
  // ----------------------------------------------------------------
  // cadence generator
  // ----------------------------------------------------------------
  logic [15:0] cnt_q;
  logic tone_q;
  assign o_tone = tone_q;
  // line goes silent when the far end stops, so no stale tone lingers
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst || !i_en)
    begin
      cnt_q <= 16'h0000;
      tone_q <= 1'b0;
    end
    else if (cnt_q + 16'h0001 >= (tone_q ? i_on_cyc : i_off_cyc))
    begin
      cnt_q <= 16'h0000;
      tone_q <= !tone_q;
    end
    else
      cnt_q <= cnt_q + 16'h0001;
  end
endmodule : mht_far_end

// ### test_mht_timing_regs.sv
// self-checking bench for the handshake timing register bank
`timescale 1ns/10ps
module test_mht_timing_regs
  import mht_pkg::*;
;
  // ----------------------------------------------------------------
  // stimulus, wiring and reset image
  // ----------------------------------------------------------------
  localparam int T = 8; // short tick keeps long timers affordable
  localparam logic [7:0] RST_EXP [35] = '{8'h00, 8'h32, 8'h32, 8'h0A, 8'h0A, 8'h0A, 8'h0A,
    8'h0A, 8'h00, 8'h0A, 8'h0A, 8'h0A, 8'h0A, 8'h0A, 8'h0A, 8'h0A, 8'h0A, 8'h0A, 8'h78, 8'h08,
    8'h00, 8'hD2, 8'h18, 8'h08, 8'h0C, 8'hF0, 8'h3C, 8'h00, 8'h3C, 8'h0C, 8'h00, 8'h5A, 8'hA2,
    8'h30, 8'h00};
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [1:0] ib_mode = 2'b00;
  logic alarm = 1'b0;
  logic [NQ-1:0] qual = '0;
  logic [NR-1:0] start = '0;
  logic fe_en = 1'b0;
  logic fe_ring = 1'b0;
  logic [15:0] fe_on = 16'h00F0;
  logic [15:0] fe_off = 16'h00F0;
  logic tone, busy_det, ring_det, kiss_echo;
  logic [7:0] rdata;
  logic [NQ-1:0] qdet;
  logic [NR-1:0] ract, rdone;
  int miscompares = 0;
  int n_checks = 0;
  // 40 MHz core clock
  always #12.5 core_clk = !core_clk;
  mht_timing_regs #(.TICK_CYCLES(T)) dut_u (.i_core_clk(core_clk), .i_sys_rst(sys_rst),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
    .i_intrusion_block_mode(ib_mode), .i_alarm_mode(alarm), .i_busy_tone(tone & !fe_ring),
    .i_ringback_tone(tone & fe_ring), .o_busy_det(busy_det), .o_ringback_det(ring_det),
    .i_qual_level(qual), .o_qual_det(qdet), .o_kissoff_echo(kiss_echo),
    .i_run_start(start), .o_run_active(ract), .o_run_done(rdone));
  mht_far_end far_u (.i_core_clk(core_clk), .i_sys_rst(sys_rst), .i_en(fe_en),
    .i_on_cyc(fe_on), .i_off_cyc(fe_off), .o_tone(tone));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : test_done
  // a bounded wait that ran out ends the run
  task automatic gate(input string nm, input logic ok);
    chk(nm, ok, 1'b1);
    if (!ok)
      test_done();
  endtask : gate
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask : wr_reg
  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    logic [7:0] v;
    for (int i = 0; i < 35; i++)
    begin
      rd_reg(8'h15 + i[7:0], v);
      chk("reset value", v, RST_EXP[i]);
    end
    @(posedge core_clk);
    #1;
    chk("rdata idle", rdata, 8'h00);
    for (int i = 0; i < 35; i++)
      wr_reg(8'h15 + i[7:0], 8'hA5 ^ i[7:0]);
    for (int i = 0; i < 35; i++)
    begin
      rd_reg(8'h15 + i[7:0], v);
      chk("readback", v, (i == 0 || i == 8 || i == 30 || i == 34) ? 8'h00 : 8'hA5 ^ i);
    end
    // write then read with no gap sees the new byte
    @(posedge core_clk);
    addr <= A_SCR_LEN;
    wdata <= 8'h10;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1;
    chk("back to back", rdata, 8'h10);
    $display("register map test done");
  endtask : t_regs
  // one interval: program, start, time the done pulse
  task automatic tmr(input int b, input logic [7:0] a1, v1, a2, v2, input int d);
    int n;
    int lo;
    wr_reg(a1, v1);
    wr_reg(a2, v2);
    @(posedge core_clk);
    start[b] <= 1'b1;
    @(posedge core_clk);
    start[b] <= 1'b0;
    n = 1;
    lo = (d == 0) ? 1 : (d - 1) * T + 1;
    #1;
    while (rdone[b] !== 1'b1 && n < d * T + 8)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    gate("timer done seen", rdone[b] === 1'b1);
    chk("timer length", n >= lo && n <= d * T + 3, 1'b1);
    $display("timer %0d test done after %0d cycles", b, n);
  endtask : tmr
  // one qualifier: raise level, time the detect, drop and see it clear
  task automatic qual_t(input int ch, input logic [7:0] a, v, input int l, input logic al);
    int n;
    logic ek;
    wr_reg(a, v);
    @(posedge core_clk);
    alarm <= al;
    qual[ch] <= 1'b1;
    n = 0;
    ek = 1'b0;
    #1;
    while (qdet[ch] !== 1'b1 && n < l * T + 8)
    begin
      @(posedge core_clk);
      #1;
      n++;
      ek = ek | kiss_echo;
    end
    gate("qualifier seen", qdet[ch] === 1'b1);
    chk("qualify time", n >= ((l == 0) ? 1 : (l - 1) * T + 1) && n <= l * T + 3, 1'b1);
    @(posedge core_clk);
    qual[ch] <= 1'b0;
    #1;
    ek = ek | kiss_echo;
    repeat (2) @(posedge core_clk);
    #1;
    chk("qualifier drop", qdet[ch], 1'b0);
    if (ch == Q_KISS)
      chk("kissoff echo", ek, al);
    $display("qualifier %0d test done after %0d cycles", ch, n);
  endtask : qual_t
  task automatic t_intr_off();
    for (int m = 0; m < 4; m++)
      if (m != 2)
      begin
        @(posedge core_clk);
        ib_mode <= m[1:0];
        start[R_INTR] <= 1'b1;
        @(posedge core_clk);
        start[R_INTR] <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
        chk("intrusion refused", {ract[R_INTR], rdone[R_INTR]}, 2'b00);
      end
    $display("intrusion mode test done");
  endtask : t_intr_off
  // far end plays a cadence until the detector reaches the expected state
  task automatic cad(input string nm, input logic ring, input logic [15:0] on, off,
    input logic exp);
    int n;
    @(posedge core_clk);
    fe_ring <= ring;
    fe_on <= on;
    fe_off <= off;
    fe_en <= 1'b1;
    n = 0;
    #1;
    while ((ring ? ring_det : busy_det) !== exp && n < 3000)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    gate(nm, (ring ? ring_det : busy_det) === exp);
    $display("cadence test %s done", nm);
  endtask : cad
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_regs();
    tmr(R_ANS_TONE, 8'h1E, 8'h00, 8'h34, 8'h03, 3);
    tmr(R_ANS_TONE, 8'h1E, 8'h01, 8'h34, 8'h03, 600);
    tmr(R_ANS_TX, 8'h1F, 8'h02, 8'h1F, 8'h02, 2);
    tmr(R_ANS_TX, 8'h1F, 8'h00, 8'h1F, 8'h00, 0);
    tmr(R_SCR_DLY, 8'h21, 8'h01, 8'h21, 8'h01, 32);
    tmr(R_SCR_TX, 8'h22, 8'h04, 8'h22, 8'h04, 4);
    tmr(R_DATA_DLY, 8'h23, 8'h02, 8'h24, 8'h01, 258);
    tmr(R_S1, 8'h25, 8'h03, 8'h25, 8'h03, 3);
    tmr(R_ONES1200, 8'h26, 8'h02, 8'h26, 8'h02, 64);
    tmr(R_ONES2400, 8'h27, 8'h01, 8'h28, 8'h01, 257);
    ib_mode <= 2'b10;
    tmr(R_INTR, 8'h29, 8'h01, 8'h29, 8'h01, 300);
    tmr(R_INTR, 8'h29, 8'h01, 8'h29, 8'h01, 300);
    t_intr_off();
    tmr(R_TURN, 8'h2C, 8'h03, 8'h2C, 8'h03, 259);
    tmr(R_REV, 8'h2E, 8'h05, 8'h2E, 8'h05, 5);
    tmr(R_FSK, 8'h2F, 8'h04, 8'h30, 8'h01, 260);
    tmr(R_OVC, 8'h32, 8'h02, 8'h32, 8'h02, 2);
    qual_t(Q_DIAL, 8'h1C, 8'h02, 12, 1'b0);
    qual_t(Q_UNSCR, 8'h20, 8'h03, 3, 1'b0);
    qual_t(Q_SCR2400, 8'h2A, 8'h04, 4, 1'b0);
    qual_t(Q_TURN, 8'h2B, 8'h05, 5, 1'b0);
    qual_t(Q_LOSS, 8'h2D, 8'h02, 2, 1'b0);
    qual_t(Q_ANS, 8'h31, 8'h06, 6, 1'b0);
    qual_t(Q_ANS, 8'h31, 8'h00, 0, 1'b0);
    qual_t(Q_KISS, 8'h36, 8'h01, 7, 1'b0);
    qual_t(Q_KISS, 8'h36, 8'h01, 7, 1'b1);
    qual_t(Q_SCR1200, 8'h35, 8'h03, 3, 1'b0);
    wr_reg(8'h16, 8'h05);
    wr_reg(8'h17, 8'h05);
    wr_reg(8'h18, 8'h01);
    wr_reg(8'h19, 8'h01);
    wr_reg(8'h1A, 8'h01);
    wr_reg(8'h1B, 8'h01);
    cad("busy good", 1'b0, 16'h00F0, 16'h00F0, 1'b1);
    cad("busy long on", 1'b0, 16'h0190, 16'h00F0, 1'b0);
    cad("ringback good", 1'b1, 16'h0100, 16'h0100, 1'b1);
    test_done();
  end
endmodule : test_mht_timing_regs
